//--- core/fbe_pkg.sv
// constants for the flash bank, erase and program control block
package fbe_pkg;
  localparam logic [7:0] FBE_SFR_ERASE = 8'h94;
  localparam logic [7:0] FBE_SFR_CTRL = 8'hB2;
  localparam logic [7:0] FBE_SFR_BANK = 8'hB6;
  localparam logic [7:0] FBE_SFR_PGADR = 8'hB7;
  localparam logic [15:0] FBE_XADR_FUSE = 16'h20FD;
  localparam int FBE_PWE_BIT = 0;
  localparam int FBE_MEEN_BIT = 1;
  localparam int FBE_FOVR_BIT = 4;
  localparam int FBE_PGADR_LSB = 2;
  localparam int FBE_PGADR_MSB = 7;
  localparam logic [7:0] FBE_CMD_PAGE = 8'h55;
  localparam logic [7:0] FBE_CMD_MASS = 8'hAA;
  localparam logic [7:0] FBE_CMD_DONE = 8'h00;
  localparam logic [2:0] FBE_BANK_RST = 3'h1;
  localparam logic [5:0] FBE_PGADR_RST = 6'h00;
  localparam int FBE_FUSE_W = 8;
  localparam int FBE_BANK_W = 3;
  localparam int FBE_FADR_W = 18;
  localparam int FBE_WIN_BIT = 15;
  typedef enum logic [1:0] {
    FBE_IDLE = 2'b00,
    FBE_PAGE = 2'b01,
    FBE_MASS = 2'b10
  } fbe_state_t;
endpackage

//--- core/fbe_addr_map.sv
// maps processor code addresses onto flash banks
`timescale 1ns/100ps
module fbe_addr_map
  import fbe_pkg::*;
(
  input wire logic [15:0] cpu_addr_i,
  input wire logic [2:0] bank_i,
  output logic [17:0] flash_addr_o
);
  always_comb begin
    if (cpu_addr_i[FBE_WIN_BIT]) begin
      flash_addr_o = {bank_i, cpu_addr_i[14:0]};
    end else begin
      flash_addr_o = {3'h0, cpu_addr_i[14:0]};
    end
  end
endmodule

//--- core/fbe_ctl.sv
// flash bank select, erase sequencer and byte program control
//
// Contract
// - address bit 15 set maps flash to bank select above address bits 14..0
// - bank select resets to one and returns to one on every erase
// - writing 0x55 to erase command starts a page erase after address write
// - writing 0xAA starts mass erase only if enable set and debug port on
// - any erase command value other than 0x55, 0xAA or 0x00 does nothing
// - erase cycle completes only when software writes 0x00
// - write-only mass erase enable permits mass erase, rewritten per cycle
// - six-bit page address with bank select picks page 0 to 127
// - program enable set routes data pointer stores of accumulator into flash
// - program enable writes ignored while interrupts globally enabled
// - fuse override set makes written values replace fuse contents
`timescale 1ns/100ps
module fbe_ctl
  import fbe_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic sfr_we_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic x_we_i,
  input wire logic [15:0] x_addr_i,
  input wire logic [7:0] x_wdata_i,
  output logic [7:0] x_rdata_o,
  input wire logic int_en_i,
  input wire logic debug_en_i,
  input wire logic [7:0] fuse_i,
  output logic [7:0] fuse_o,
  input wire logic [15:0] code_addr_i,
  output logic [17:0] code_flash_addr_o,
  output logic [17:0] prog_addr_o,
  output logic [7:0] prog_data_o,
  output logic prog_we_o,
  output logic ram_we_o,
  output logic page_erase_o,
  output logic mass_erase_o,
  output logic [6:0] erase_page_o
);
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  logic [2:0] bank_q;
  logic [5:0] pgadr_q;
  logic pgadr_vld_q, meen_q, pwe_q, fovr_q;
  logic [7:0] fuse_ovr_q;
  fbe_state_t state_q, state_d;
  logic [17:0] prog_addr_q;
  logic [7:0] prog_data_q;
  logic prog_we_q, ram_we_q;
  logic [17:0] x_flash_addr;
  logic [6:0] epage_q;

  logic wr_erase, wr_ctrl, wr_bank, wr_pgadr, wr_fuse;
  logic start_page, start_mass, done_wr;
  assign wr_erase = sfr_we_i && sfr_addr_i == FBE_SFR_ERASE;
  assign wr_ctrl = sfr_we_i && sfr_addr_i == FBE_SFR_CTRL;
  assign wr_bank = sfr_we_i && sfr_addr_i == FBE_SFR_BANK;
  assign wr_pgadr = sfr_we_i && sfr_addr_i == FBE_SFR_PGADR;
  // override store only in data space
  assign wr_fuse = x_we_i && !pwe_q && x_addr_i == FBE_XADR_FUSE;
  assign start_page = wr_erase && sfr_wdata_i == FBE_CMD_PAGE && pgadr_vld_q
                      && state_q == FBE_IDLE;
  assign start_mass = wr_erase && sfr_wdata_i == FBE_CMD_MASS && meen_q && debug_en_i
                      && state_q == FBE_IDLE;
  assign done_wr = wr_erase && sfr_wdata_i == FBE_CMD_DONE;

  always_comb begin
    state_d = state_q;
    case (state_q)
      FBE_IDLE: begin
        if (start_page) begin
          state_d = FBE_PAGE;
        end else if (start_mass) begin
          state_d = FBE_MASS;
        end
      end
      FBE_PAGE, FBE_MASS: begin
        if (done_wr) begin
          state_d = FBE_IDLE;
        end
      end
      default: state_d = FBE_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= FBE_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bank_q <= FBE_BANK_RST;
    end else if (start_page || start_mass) begin
      bank_q <= FBE_BANK_RST;
    end else if (wr_bank) begin
      bank_q <= sfr_wdata_i[FBE_BANK_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pgadr_q <= FBE_PGADR_RST;
      pgadr_vld_q <= 1'b0;
    end else if (wr_pgadr) begin
      pgadr_q <= sfr_wdata_i[FBE_PGADR_MSB:FBE_PGADR_LSB];
      pgadr_vld_q <= 1'b1;
    end else if (start_page) begin
      pgadr_vld_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      meen_q <= 1'b0;
    end else if (wr_ctrl) begin
      meen_q <= sfr_wdata_i[FBE_MEEN_BIT];
    end else if (start_page || start_mass) begin
      meen_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pwe_q <= 1'b0;
    end else if (wr_ctrl && !int_en_i) begin
      pwe_q <= sfr_wdata_i[FBE_PWE_BIT];
    end
  end

  // store routing to flash or ram
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prog_we_q <= 1'b0;
      ram_we_q <= 1'b0;
      prog_addr_q <= '0;
      prog_data_q <= '0;
    end else begin
      prog_we_q <= x_we_i && pwe_q;
      ram_we_q <= x_we_i && !pwe_q;
      if (x_we_i) begin
        prog_addr_q <= x_flash_addr;
        prog_data_q <= x_wdata_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fovr_q <= 1'b0;
      fuse_ovr_q <= '0;
    end else begin
      if (wr_fuse) begin
        fovr_q <= x_wdata_i[FBE_FOVR_BIT];
      end
      if (wr_fuse) begin
        fuse_ovr_q <= x_wdata_i;
      end
    end
  end
  assign fuse_o = fovr_q ? fuse_ovr_q : fuse_i;

  always_comb begin
    case (sfr_addr_i)
      FBE_SFR_CTRL: sfr_rdata_o = {7'h00, pwe_q};
      FBE_SFR_BANK: sfr_rdata_o = {5'h00, bank_q};
      default: sfr_rdata_o = 8'h00;
    endcase
  end
  assign x_rdata_o = (x_addr_i == FBE_XADR_FUSE) ? {3'h0, fovr_q, 4'h0} : 8'h00;

  fbe_addr_map u_map (
    .cpu_addr_i(code_addr_i),
    .bank_i(bank_q),
    .flash_addr_o(code_flash_addr_o)
  );

  // store address through same bank window
  fbe_addr_map u_prog_map (
    .cpu_addr_i(x_addr_i),
    .bank_i(bank_q),
    .flash_addr_o(x_flash_addr)
  );

  assign prog_addr_o = prog_addr_q;
  assign prog_data_o = prog_data_q;
  assign prog_we_o = prog_we_q;
  assign ram_we_o = ram_we_q;
  assign page_erase_o = state_q == FBE_PAGE;
  assign mass_erase_o = state_q == FBE_MASS;
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      epage_q <= '0;
    end else if (start_page) begin
      epage_q <= {bank_q[0], pgadr_q};
    end
  end
  assign erase_page_o = epage_q;

  property p_page_start;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      start_page |=> page_erase_o && bank_q == FBE_BANK_RST
                     && erase_page_o == {$past(bank_q[0]), $past(pgadr_q)};
  endproperty
  a_page_start: assert property (p_page_start) else $error("page erase not started");
  property p_mass_gate;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      $rose(mass_erase_o) |-> $past(meen_q) && $past(debug_en_i);
  endproperty
  a_mass_gate: assert property (p_mass_gate) else $error("mass erase ungated");
  property p_bank_rst;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      (start_page || start_mass) |=> bank_q == FBE_BANK_RST;
  endproperty
  a_bank_rst: assert property (p_bank_rst) else $error("bank not reset");
  property p_hold;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      (state_q != FBE_IDLE && !done_wr) |=> state_q == $past(state_q);
  endproperty
  a_hold: assert property (p_hold) else $error("erase ended early");
  property p_done;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      done_wr |=> state_q == FBE_IDLE;
  endproperty
  a_done: assert property (p_done) else $error("erase not ended");
  property p_other;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      (state_q == FBE_IDLE && !start_page && !start_mass) |=> state_q == FBE_IDLE;
  endproperty
  a_other: assert property (p_other) else $error("spurious erase");
  property p_meen_once;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      start_mass |=> !meen_q;
  endproperty
  a_meen_once: assert property (p_meen_once) else $error("enable kept");
  property p_pwe_lock;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      int_en_i |=> $stable(pwe_q);
  endproperty
  a_pwe_lock: assert property (p_pwe_lock) else $error("enable changed");
  property p_prog;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      (x_we_i && pwe_q) |=> prog_we_o && !ram_we_o && prog_data_o == $past(x_wdata_i);
  endproperty
  a_prog: assert property (p_prog) else $error("flash store lost");
  property p_map;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      code_addr_i[FBE_WIN_BIT] |-> code_flash_addr_o[17:15] == bank_q;
  endproperty
  a_map: assert property (p_map) else $error("bank map wrong");
  property p_fuse;
    @(posedge ref_clk_i) disable iff (!rst_n_q)
      fovr_q |-> fuse_o == fuse_ovr_q;
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse not overridden");

  c_page: cover property (@(posedge ref_clk_i) disable iff (!rst_n_q) start_page ##[1:20] done_wr);
  c_mass: cover property (@(posedge ref_clk_i) disable iff (!rst_n_q) start_mass);
  c_prog: cover property (@(posedge ref_clk_i) disable iff (!rst_n_q) prog_we_o);
endmodule

//--- verification/fbe_flash_model.sv
// behavioural flash model that logs the last byte write and counts byte writes
`timescale 1ns/100ps
module fbe_flash_model (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [17:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [17:0] last_addr_o,
  output logic [7:0] last_data_o,
  output logic [7:0] n_prog_o
);
  initial n_prog_o = 8'h00;
  always @(posedge clk_i) begin
    if (we_i) begin
      last_addr_o <= addr_i;
      last_data_o <= data_i;
      n_prog_o <= n_prog_o + 8'h01;
    end
  end
endmodule

//--- verification/fbe_ctl_tb.sv
// self-checking bench for the flash control block
`timescale 1ns/100ps
module fbe_ctl_tb;
  import fbe_pkg::*;
  logic clk = 0, rstn = 0, swe = 0, xwe = 0, ien = 0, dbg = 0;
  logic [7:0] sa = 0, sd = 0, xd = 0, fuse = 8'h3C, srd, xrd, fo, pd, m_data, m_np, np, fv;
  logic [15:0] xa = 0, ca = 0;
  logic [17:0] cfa, pa, m_addr;
  logic pwo, rwe, pe, me;
  logic [6:0] ep;
  logic [31:0] rs = 32'h9CDE;
  int n_mismatch = 0, checks_done = 0, nram = 0, nr = 0;
  always #10 clk = ~clk;
  always @(posedge clk) if (rwe === 1'b1) nram++;
  fbe_ctl fbe_ctl_inst (.ref_clk_i(clk), .rstn_i(rstn), .sfr_we_i(swe), .sfr_addr_i(sa),
    .sfr_wdata_i(sd), .sfr_rdata_o(srd), .x_we_i(xwe), .x_addr_i(xa), .x_wdata_i(xd),
    .x_rdata_o(xrd), .int_en_i(ien), .debug_en_i(dbg), .fuse_i(fuse), .fuse_o(fo),
    .code_addr_i(ca), .code_flash_addr_o(cfa), .prog_addr_o(pa), .prog_data_o(pd),
    .prog_we_o(pwo), .ram_we_o(rwe), .page_erase_o(pe), .mass_erase_o(me), .erase_page_o(ep));
  fbe_flash_model fbe_flash_model_inst (.clk_i(clk), .we_i(pwo), .addr_i(pa), .data_i(pd),
    .last_addr_o(m_addr), .last_data_o(m_data), .n_prog_o(m_np));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [17:0] emap(input logic [2:0] b, input logic [15:0] a);
    return a[15] ? {b, a[14:0]} : {3'h0, a[14:0]};
  endfunction
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    sa = a;
    sd = d;
    swe = 1;
    @(negedge clk);
    swe = 0;
    @(negedge clk);
  endtask
  task automatic xw(input logic [15:0] a, input logic [7:0] d);
    xa = a;
    xd = d;
    xwe = 1;
    @(negedge clk);
    xwe = 0;
    repeat (2) @(negedge clk);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    final_report;
  end
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1;
    repeat (3) @(negedge clk);
    sa = FBE_SFR_BANK;
    #1 chk("bank_rst", 18'h1, srd);
    for (int i = 0; i < 24; i++) begin
      rs = xs(rs);
      sw(FBE_SFR_BANK, {5'h0, rs[18:16]});
      ca = rs[15:0];
      #1 chk("code_map", emap(rs[18:16], ca), cfa);
    end
    $display("bank map test done");
    sw(FBE_SFR_BANK, 8'h05);
    sw(FBE_SFR_PGADR, 8'hFC);
    sw(FBE_SFR_ERASE, FBE_CMD_PAGE);
    chk("page_start", 18'h1, pe);
    chk("page_num", 18'h7F, ep);
    sa = FBE_SFR_BANK;
    #1 chk("bank_erase", 18'h1, srd);
    sw(FBE_SFR_ERASE, FBE_CMD_DONE);
    chk("page_done", 18'h0, pe);
    sw(FBE_SFR_ERASE, FBE_CMD_PAGE);
    chk("page_stale", 18'h0, pe);
    sw(FBE_SFR_PGADR, 8'h00);
    sw(FBE_SFR_ERASE, 8'h56);
    chk("odd_cmd", 18'h0, {pe, me});
    sw(FBE_SFR_ERASE, FBE_CMD_PAGE);
    chk("page_zero", 18'h1, {pe, ep} === 8'hC0);
    sw(FBE_SFR_ERASE, FBE_CMD_DONE);
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      sw(FBE_SFR_BANK, {5'h0, rs[2:0]});
      sw(FBE_SFR_PGADR, rs[15:8]);
      sw(FBE_SFR_ERASE, FBE_CMD_PAGE);
      chk("page_rand", {11'h0, rs[0], rs[15:10]}, ep);
      sw(FBE_SFR_ERASE, {rs[23:17], 1'b1});
      chk("page_hold", 18'h1, pe);
      sa = FBE_SFR_BANK;
      #1 chk("page_bank", 18'h1, srd);
      sw(FBE_SFR_ERASE, FBE_CMD_DONE);
    end
    $display("page erase test done");
    dbg = 1;
    sw(FBE_SFR_ERASE, FBE_CMD_MASS);
    chk("mass_nomeen", 18'h0, me);
    sw(FBE_SFR_CTRL, 8'h02);
    dbg = 0;
    sw(FBE_SFR_ERASE, FBE_CMD_MASS);
    chk("mass_nodbg", 18'h0, me);
    dbg = 1;
    sw(FBE_SFR_BANK, 8'h06);
    sw(FBE_SFR_CTRL, 8'h02);
    sw(FBE_SFR_ERASE, FBE_CMD_MASS);
    chk("mass_start", 18'h1, me);
    sa = FBE_SFR_BANK;
    #1 chk("mass_bank", 18'h1, srd);
    sw(FBE_SFR_ERASE, FBE_CMD_DONE);
    chk("mass_done", 18'h0, me);
    sw(FBE_SFR_ERASE, FBE_CMD_MASS);
    chk("meen_used", 18'h0, me);
    $display("mass erase test done");
    ien = 1;
    sw(FBE_SFR_CTRL, 8'h01);
    sa = FBE_SFR_CTRL;
    #1 chk("pwe_ien", 18'h0, srd);
    ien = 0;
    for (int i = 0; i < 6; i++) begin
      rs = xs(rs);
      np = m_np;
      sw(FBE_SFR_BANK, {5'h0, rs[26:24]});
      sw(FBE_SFR_CTRL, 8'h01);
      #1 chk("pwe_set", 18'h1, srd);
      xw(rs[15:0], rs[23:16]);
      chk("prog_addr", emap(rs[26:24], rs[15:0]), m_addr);
      chk("prog_data", rs[23:16], m_data);
      chk("prog_cnt", np + 8'h01, m_np);
      sw(FBE_SFR_CTRL, 8'h00);
    end
    np = m_np;
    nr = nram;
    xw(16'h0123, 8'h5A);
    chk("ram_store", {np, 8'h01}, {m_np, 8'(nram - nr)});
    $display("program test done");
    rs = xs(rs);
    fuse = rs[7:0];
    fv = {rs[15:13], 1'b1, rs[11:8]};
    xw(FBE_XADR_FUSE, fv);
    chk("fuse_ovr", fv, fo);
    xa = FBE_XADR_FUSE;
    #1 chk("fuse_rd", 18'h10, xrd);
    sw(FBE_SFR_CTRL, 8'h01);
    xw(FBE_XADR_FUSE, 8'h00);
    chk("fuse_pwe", fv, fo);
    sw(FBE_SFR_CTRL, 8'h00);
    xw(FBE_XADR_FUSE, 8'h00);
    chk("fuse_off", fuse, fo);
    $display("fuse test done");
    sw(FBE_SFR_PGADR, 8'h10);
    sw(FBE_SFR_ERASE, FBE_CMD_PAGE);
    sw(FBE_SFR_BANK, 8'h04);
    xw(FBE_XADR_FUSE, 8'h10);
    rstn = 0;
    #1 chk("rst_fuse", fuse, fo);
    chk("rst_erase", 18'h0, {pe, me});
    repeat (3) @(negedge clk);
    rstn = 1;
    repeat (3) @(negedge clk);
    sa = FBE_SFR_BANK;
    #1 chk("rst_bank", 18'h1, srd);
    @(negedge clk);
    sw(FBE_SFR_ERASE, FBE_CMD_PAGE);
    chk("rst_pgadr", 18'h0, pe);
    $display("reset test done");
    final_report;
  end
endmodule
